// *** modbus_wr_pkg.sv ***
// Constants, state encoding and frame layout for the register-write and loopback command handler
// ==========================================
// Summary of operation
// - Good single write echoes request frame
// - Bad single-write address: 02h, two counters
// - Bad value 03h; malformed 03h, bad packet
// - Only command, selector, date/time registers writable
// - Loopback subfunction 0000h returns request copy
// - Loopback reply data equals request data
// - Other subfunction 03h; malformed 03h, bad packet
// - Multi-write sets at most 100 registers
// - Multi-write: addr, 10h, start, count, n, data, CRC
// - Multi-write reply: addr, 10h, start, count, CRC
// - Unwritable multi-write target: 02h, two counters
// - Count out of range: 03h, two counters
// - Byte count mismatch: 03h, two counters
// - Bad multi-write value: 03h, illegal write
package modbus_wr_pkg;
    // ==========================================
    // Function and exception codes
    localparam logic [7:0] FC_WRITE_ONE = 8'h06;
    localparam logic [7:0] FC_LOOPBACK = 8'h08;
    localparam logic [7:0] FC_WRITE_MANY = 8'h10;
    localparam logic [7:0] FC_EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
    localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
    localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
    localparam logic [15:0] SUB_ECHO = 16'h0000;
    // ==========================================
    // Frame layout and sizes
    localparam int FRAME_DEPTH = 256;
    localparam logic [8:0] LEN_FIXED = 9'h008;
    localparam logic [8:0] LEN_MULTI_HDR = 9'h009;
    localparam logic [8:0] LEN_MIN = 9'h004;
    localparam logic [8:0] LEN_REPLY = 9'h006;
    localparam logic [8:0] LEN_EXC = 9'h003;
    localparam logic [8:0] DATA_ONE = 9'h004;
    localparam logic [8:0] DATA_MANY = 9'h007;
    localparam logic [15:0] MAX_REGS = 16'h0064;
    // ==========================================
    // CRC-16, reflected polynomial
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    // ==========================================
    // Writable register windows and selector value limit
    localparam logic [15:0] CMD_BASE = 16'h0100;
    localparam logic [15:0] CMD_LAST = 16'h0107;
    localparam logic [15:0] SELECTOR_ADDR = 16'h0180;
    localparam logic [15:0] SELECTOR_MAX = 16'h00FF;
    localparam logic [15:0] TIME_BASE = 16'h0200;
    localparam logic [15:0] TIME_LAST = 16'h0205;
    // ==========================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_RECV = 3'b000,
        ST_DECODE = 3'b001,
        ST_SCAN = 3'b010,
        ST_WRITE = 3'b011,
        ST_REPLY = 3'b100
    } state_t;
endpackage

// *** modbus_register_write_loopback.sv ***
// Frame receiver, checker, register writer and reply sender for functions 06h, 08h and 10h
`timescale 1ns/1ps
module modbus_register_write_loopback #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Own station address
    input wire logic [7:0] stationAddr,
    // Received bytes from the framing layer
    input wire logic rxValid,
    input wire logic [7:0] rxByte,
    input wire logic rxEnd,
    // Reply bytes to the framing layer
    output logic txValid,
    output logic [7:0] txByte,
    output logic txLast,
    input wire logic txReady,
    // Register write port
    output logic wrStrobe,
    output logic [15:0] wrAddr,
    output logic [15:0] wrData,
    // Diagnostic counters
    output logic [CNT_W-1:0] badPacketCnt,
    output logic [CNT_W-1:0] invalidAddrCnt,
    output logic [CNT_W-1:0] illegalWriteCnt,
    output logic [CNT_W-1:0] illegalFuncCnt,
    output logic [CNT_W-1:0] illegalRegCnt
);
    // ==========================================
    // Elaboration check
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
        $error("CNT_W must lie between 1 and 32");
    end

    // ==========================================
    // State
    typedef struct packed {
        modbus_wr_pkg::state_t state;
        logic [modbus_wr_pkg::FRAME_DEPTH-1:0][7:0] frame;
        logic [8:0] len;
        logic ovf;
        logic [15:0] crc;
        logic [15:0] startAddr;
        logic [7:0] cnt;
        logic [7:0] k;
        logic [8:0] ptr;
        logic addrBad;
        logic valBad;
        logic [8:0] txLen;
        logic txValid;
        logic [7:0] txByte;
        logic txLast;
        logic wrStrobe;
        logic [15:0] wrAddr;
        logic [15:0] wrData;
        logic [CNT_W-1:0] badPacketCnt;
        logic [CNT_W-1:0] invalidAddrCnt;
        logic [CNT_W-1:0] illegalWriteCnt;
        logic [CNT_W-1:0] illegalFuncCnt;
        logic [CNT_W-1:0] illegalRegCnt;
    } core_t;

    core_t r;
    core_t next_r;

    // One byte of the reflected CRC-16
    function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] x;
        x = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ modbus_wr_pkg::CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    // Writable windows
    function automatic logic addrOk(input logic [15:0] a);
        return (a >= modbus_wr_pkg::CMD_BASE && a <= modbus_wr_pkg::CMD_LAST) ||
               (a == modbus_wr_pkg::SELECTOR_ADDR) ||
               (a >= modbus_wr_pkg::TIME_BASE && a <= modbus_wr_pkg::TIME_LAST);
    endfunction

    // Only the selector has a bounded value range
    function automatic logic valueOk(input logic [15:0] a, input logic [15:0] d);
        return (a != modbus_wr_pkg::SELECTOR_ADDR) || (d <= modbus_wr_pkg::SELECTOR_MAX);
    endfunction

    // ==========================================
    // Next-state logic
    always_comb begin
        logic [7:0] fc;
        logic [15:0] word23;
        logic [15:0] word45;
        logic [15:0] curAddr;
        logic [15:0] curData;
        logic doExc;
        logic [7:0] excCode;
        logic incBad;
        logic incInvA;
        logic incIllW;
        logic incIllF;
        logic incIllR;
        logic lastReg;
        fc = r.frame[1];
        word23 = {r.frame[2], r.frame[3]};
        word45 = {r.frame[4], r.frame[5]};
        curAddr = r.startAddr + {8'h00, r.k};
        curData = {r.frame[r.ptr[7:0]], r.frame[r.ptr[7:0] + 8'h01]};
        doExc = 1'b0;
        excCode = modbus_wr_pkg::EXC_BAD_VALUE;
        incBad = 1'b0;
        incInvA = 1'b0;
        incIllW = 1'b0;
        incIllF = 1'b0;
        incIllR = 1'b0;
        lastReg = (r.k == r.cnt - 8'h01);
        next_r = r;
        next_r.wrStrobe = 1'b0;
        case (r.state)
            // Collect bytes; the running CRC over a whole good frame ends at zero
            modbus_wr_pkg::ST_RECV: begin
                if (rxEnd) begin
                    next_r.len = '0;
                    next_r.ovf = 1'b0;
                    next_r.crc = modbus_wr_pkg::CRC_INIT;
                    if (r.crc == 16'h0000 && !r.ovf && r.len >= modbus_wr_pkg::LEN_MIN &&
                        r.frame[0] == stationAddr) begin
                        next_r.state = modbus_wr_pkg::ST_DECODE;
                        next_r.len = r.len;
                    end
                end else if (rxValid) begin
                    if (r.len < 9'(modbus_wr_pkg::FRAME_DEPTH)) begin
                        next_r.frame[r.len[7:0]] = rxByte;
                        next_r.len = r.len + 9'h001;
                        next_r.crc = crcByte(r.crc, rxByte);
                    end else begin
                        next_r.ovf = 1'b1;
                    end
                end
            end
            // Check format and fields before touching any register
            modbus_wr_pkg::ST_DECODE: begin
                next_r.k = '0;
                next_r.addrBad = 1'b0;
                next_r.valBad = 1'b0;
                case (fc)
                    modbus_wr_pkg::FC_WRITE_ONE: begin
                        if (r.len != modbus_wr_pkg::LEN_FIXED) begin
                            doExc = 1'b1;
                            incBad = 1'b1;
                        end else begin
                            next_r.startAddr = word23;
                            next_r.cnt = 8'h01;
                            next_r.ptr = modbus_wr_pkg::DATA_ONE;
                            next_r.state = modbus_wr_pkg::ST_SCAN;
                        end
                    end
                    modbus_wr_pkg::FC_LOOPBACK: begin
                        if (r.len != modbus_wr_pkg::LEN_FIXED) begin
                            doExc = 1'b1;
                            incBad = 1'b1;
                        end else if (word23 != modbus_wr_pkg::SUB_ECHO) begin
                            doExc = 1'b1;
                            incIllF = 1'b1;
                        end else begin
                            next_r.txLen = modbus_wr_pkg::LEN_REPLY;
                            next_r.state = modbus_wr_pkg::ST_REPLY;
                        end
                    end
                    modbus_wr_pkg::FC_WRITE_MANY: begin
                        if (r.len < modbus_wr_pkg::LEN_MULTI_HDR) begin
                            doExc = 1'b1;
                            incBad = 1'b1;
                        end else if (word45 == 16'h0000 || word45 > modbus_wr_pkg::MAX_REGS) begin
                            doExc = 1'b1;
                            incIllR = 1'b1;
                            incIllW = 1'b1;
                        end else if ({8'h00, r.frame[6]} != {word45[14:0], 1'b0} ||
                                     r.len != modbus_wr_pkg::LEN_MULTI_HDR + {1'b0, r.frame[6]}) begin
                            doExc = 1'b1;
                            incBad = 1'b1;
                            incIllW = 1'b1;
                        end else begin
                            next_r.startAddr = word23;
                            next_r.cnt = word45[7:0];
                            next_r.ptr = modbus_wr_pkg::DATA_MANY;
                            next_r.state = modbus_wr_pkg::ST_SCAN;
                        end
                    end
                    default: begin
                        // Functions outside this block get the generic refusal
                        doExc = 1'b1;
                        excCode = modbus_wr_pkg::EXC_BAD_FUNC;
                        incIllF = 1'b1;
                    end
                endcase
            end
            // Validate every target first so a refused request writes nothing
            modbus_wr_pkg::ST_SCAN: begin
                next_r.addrBad = r.addrBad | !addrOk(curAddr);
                next_r.valBad = r.valBad | !valueOk(curAddr, curData);
                next_r.k = r.k + 8'h01;
                next_r.ptr = r.ptr + 9'h002;
                if (lastReg) begin
                    next_r.k = '0;
                    next_r.ptr = (fc == modbus_wr_pkg::FC_WRITE_ONE) ? modbus_wr_pkg::DATA_ONE
                                                                    : modbus_wr_pkg::DATA_MANY;
                    if (next_r.addrBad) begin
                        doExc = 1'b1;
                        excCode = modbus_wr_pkg::EXC_BAD_ADDR;
                        incInvA = 1'b1;
                        incIllW = 1'b1;
                    end else if (next_r.valBad) begin
                        doExc = 1'b1;
                        incIllW = 1'b1;
                    end else begin
                        next_r.state = modbus_wr_pkg::ST_WRITE;
                    end
                end
            end
            // One register per cycle
            modbus_wr_pkg::ST_WRITE: begin
                next_r.wrStrobe = 1'b1;
                next_r.wrAddr = curAddr;
                next_r.wrData = curData;
                next_r.k = r.k + 8'h01;
                next_r.ptr = r.ptr + 9'h002;
                if (lastReg) begin
                    next_r.txLen = modbus_wr_pkg::LEN_REPLY;
                    next_r.state = modbus_wr_pkg::ST_REPLY;
                end
            end
            // Head bytes from the frame store, then CRC low and high
            modbus_wr_pkg::ST_REPLY: begin
                if (!r.txValid || txReady) begin
                    next_r.ptr = r.ptr + 9'h001;
                    next_r.txValid = 1'b1;
                    next_r.txLast = 1'b0;
                    if (r.ptr < r.txLen) begin
                        next_r.txByte = r.frame[r.ptr[7:0]];
                        next_r.crc = crcByte(r.crc, r.frame[r.ptr[7:0]]);
                    end else if (r.ptr == r.txLen) begin
                        next_r.txByte = r.crc[7:0];
                    end else if (r.ptr == r.txLen + 9'h001) begin
                        next_r.txByte = r.crc[15:8];
                        next_r.txLast = 1'b1;
                    end else begin
                        next_r.txValid = 1'b0;
                        next_r.txLast = 1'b0;
                        next_r.len = '0;
                        next_r.crc = modbus_wr_pkg::CRC_INIT;
                        next_r.state = modbus_wr_pkg::ST_RECV;
                    end
                end
            end
            default: begin
                next_r.state = modbus_wr_pkg::ST_RECV;
            end
        endcase
        // Exception reply reuses the frame store head
        if (doExc) begin
            next_r.frame[1] = fc | modbus_wr_pkg::FC_EXC_FLAG;
            next_r.frame[2] = excCode;
            next_r.txLen = modbus_wr_pkg::LEN_EXC;
            next_r.state = modbus_wr_pkg::ST_REPLY;
        end
        if (next_r.state == modbus_wr_pkg::ST_REPLY && r.state != modbus_wr_pkg::ST_REPLY) begin
            next_r.ptr = '0;
            next_r.crc = modbus_wr_pkg::CRC_INIT;
        end
        // Counters wrap; software compares differences
        next_r.badPacketCnt = r.badPacketCnt + CNT_W'(incBad);
        next_r.invalidAddrCnt = r.invalidAddrCnt + CNT_W'(incInvA);
        next_r.illegalWriteCnt = r.illegalWriteCnt + CNT_W'(incIllW);
        next_r.illegalFuncCnt = r.illegalFuncCnt + CNT_W'(incIllF);
        next_r.illegalRegCnt = r.illegalRegCnt + CNT_W'(incIllR);
    end

    // ==========================================
    // State register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
            r.crc <= modbus_wr_pkg::CRC_INIT;
        end else begin
            r <= next_r;
        end
    end

    assign txValid = r.txValid;
    assign txByte = r.txByte;
    assign txLast = r.txLast;
    assign wrStrobe = r.wrStrobe;
    assign wrAddr = r.wrAddr;
    assign wrData = r.wrData;
    assign badPacketCnt = r.badPacketCnt;
    assign invalidAddrCnt = r.invalidAddrCnt;
    assign illegalWriteCnt = r.illegalWriteCnt;
    assign illegalFuncCnt = r.illegalFuncCnt;
    assign illegalRegCnt = r.illegalRegCnt;

    // ==========================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    AST_BAD_CRC_DROP: assert property (
        r.state == modbus_wr_pkg::ST_RECV && rxEnd && r.crc != 16'h0000 |=> r.state == modbus_wr_pkg::ST_RECV
    ) else $error("frame with bad CRC was not dropped");
    AST_WRITE_IN_WINDOW: assert property (
        wrStrobe |-> addrOk(wrAddr)
    ) else $error("write outside writable registers");
    AST_WRITE_COUNT: assert property (
        r.state == modbus_wr_pkg::ST_WRITE |-> r.cnt != 8'h00 && {8'h00, r.cnt} <= modbus_wr_pkg::MAX_REGS
    ) else $error("more registers written than allowed");
    AST_EXC_TOPBIT: assert property (
        r.state == modbus_wr_pkg::ST_REPLY && r.txLen == modbus_wr_pkg::LEN_EXC |-> r.frame[1][7]
    ) else $error("exception reply lacks flagged function code");
    AST_BAD_ADDR_COUNT: assert property (
        r.state == modbus_wr_pkg::ST_SCAN && r.k == r.cnt - 8'h01 &&
        (r.addrBad || !addrOk(r.startAddr + {8'h00, r.k}))
        |=> invalidAddrCnt == $past(invalidAddrCnt) + CNT_W'(1) && illegalWriteCnt == $past(illegalWriteCnt) + CNT_W'(1)
            && r.frame[2] == modbus_wr_pkg::EXC_BAD_ADDR
    ) else $error("address exception not counted");
    AST_ECHO: assert property (
        r.state == modbus_wr_pkg::ST_DECODE && r.frame[1] == modbus_wr_pkg::FC_LOOPBACK &&
        r.len == modbus_wr_pkg::LEN_FIXED && {r.frame[2], r.frame[3]} == modbus_wr_pkg::SUB_ECHO
        |=> r.state == modbus_wr_pkg::ST_REPLY && r.txLen == modbus_wr_pkg::LEN_REPLY && $stable(r.frame[5:2])
    ) else $error("loopback not echoed");
    AST_BAD_SUB: assert property (
        r.state == modbus_wr_pkg::ST_DECODE && r.frame[1] == modbus_wr_pkg::FC_LOOPBACK &&
        r.len == modbus_wr_pkg::LEN_FIXED && {r.frame[2], r.frame[3]} != modbus_wr_pkg::SUB_ECHO
        |=> illegalFuncCnt == $past(illegalFuncCnt) + CNT_W'(1) && r.frame[2] == modbus_wr_pkg::EXC_BAD_VALUE
    ) else $error("bad subfunction not refused");
    AST_ZERO_COUNT: assert property (
        r.state == modbus_wr_pkg::ST_DECODE && r.frame[1] == modbus_wr_pkg::FC_WRITE_MANY &&
        r.len >= modbus_wr_pkg::LEN_MULTI_HDR && {r.frame[4], r.frame[5]} == 16'h0000
        |=> illegalRegCnt == $past(illegalRegCnt) + CNT_W'(1) && r.state == modbus_wr_pkg::ST_REPLY
    ) else $error("zero register count not refused");
    AST_LAST_ENDS: assert property (
        txValid && txReady && txLast |=> !txValid ##1 r.state == modbus_wr_pkg::ST_RECV
    ) else $error("reply did not end after last byte");
    AST_TX_HOLD: assert property (
        txValid && !txReady |=> txValid && $stable(txByte)
    ) else $error("reply byte changed while stalled");

    COV_SINGLE_WRITE: cover property (r.state == modbus_wr_pkg::ST_WRITE && r.cnt == 8'h01);
    COV_MULTI_WRITE: cover property (r.state == modbus_wr_pkg::ST_WRITE && r.cnt > 8'h01);
    COV_LOOPBACK: cover property (r.state == modbus_wr_pkg::ST_REPLY && r.frame[1] == modbus_wr_pkg::FC_LOOPBACK);
    COV_EXCEPTION: cover property (txValid && txLast && r.txLen == modbus_wr_pkg::LEN_EXC);
endmodule

// *** proto_master.sv ***
// Remote protocol master model: sends request frames and gathers reply bytes
`timescale 1ns/1ps
module proto_master (
    // Clock
    input wire logic mclk,
    // Request bytes towards the block
    output logic rxValid,
    output logic [7:0] rxByte,
    output logic rxEnd,
    // Reply bytes from the block
    input wire logic txValid,
    input wire logic [7:0] txByte,
    input wire logic txLast,
    output logic txReady
);
    logic [7:0] reply[$];
    logic done;
    logic stall;
    int lastPos;
    // Idle line at time zero
    initial begin
        rxValid = 1'b0;
        rxByte = 8'h00;
        rxEnd = 1'b0;
        txReady = 1'b0;
        stall = 1'b0;
        done = 1'b0;
        lastPos = 0;
    end
    // ==========================================
    // Request side
    // Whole frame in order, one byte a cycle, then the end marker alone
    task automatic send(input logic [7:0] fr[$]);
        foreach (fr[i]) begin
            @(negedge mclk);
            rxValid = 1'b1;
            rxByte = fr[i];
        end
        @(negedge mclk);
        rxValid = 1'b0;
        rxByte = ~rxByte; // Line no longer holds a byte, so never the last value
        rxEnd = 1'b1;
        @(negedge mclk);
        rxEnd = 1'b0;
    endtask
    task automatic clear();
        reply.delete();
        done = 1'b0;
        lastPos = 0;
    endtask
    // ==========================================
    // Reply side
    // Stalling toggles readiness so every reply byte after the first must be held
    always @(negedge mclk) begin
        txReady <= stall ? ~txReady : 1'b1;
    end
    // Byte taken on the accepting edge; the last marker closes the reply
    always @(posedge mclk) begin
        if (txValid === 1'b1 && txReady === 1'b1) begin
            reply.push_back(txByte);
            if (txLast === 1'b1) begin
                done = 1'b1;
                lastPos = reply.size();
            end
        end
    end
endmodule

// *** tb_top.sv ***
// Self-checking testbench for the register-write and loopback command handler
`timescale 1ns/1ps
module tb_top;
    typedef logic [7:0] bytes_t[$];
    localparam logic [7:0] STN = 8'h11;
    logic mclk, arst_n, rxValid, rxEnd, txValid, txLast, txReady, wrStrobe;
    logic [7:0] rxByte, txByte;
    logic [15:0] wrAddr, wrData, badPacketCnt, invalidAddrCnt, illegalWriteCnt, illegalFuncCnt, illegalRegCnt;
    logic [31:0] wrQ[$];
    bytes_t none;
    int num_errors, n_checks, eBp, eIa, eIw, eIf, eIr;
    // ==========================================
    // Clock, design and master model
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    modbus_register_write_loopback #(.CNT_W(16)) u_dut (.mclk(mclk), .arst_n(arst_n), .stationAddr(STN),
        .rxValid(rxValid), .rxByte(rxByte), .rxEnd(rxEnd), .txValid(txValid), .txByte(txByte), .txLast(txLast),
        .txReady(txReady), .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData), .badPacketCnt(badPacketCnt),
        .invalidAddrCnt(invalidAddrCnt), .illegalWriteCnt(illegalWriteCnt), .illegalFuncCnt(illegalFuncCnt),
        .illegalRegCnt(illegalRegCnt));
    proto_master u_master (.mclk(mclk), .rxValid(rxValid), .rxByte(rxByte), .rxEnd(rxEnd), .txValid(txValid),
        .txByte(txByte), .txLast(txLast), .txReady(txReady));
    // Register writes logged as address and value
    always @(posedge mclk) begin
        if (wrStrobe === 1'b1) wrQ.push_back({wrAddr, wrData});
    end
    // ==========================================
    // Checking helpers
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_counts();
        check_val("bad packet count", eBp, badPacketCnt);
        check_val("invalid address count", eIa, invalidAddrCnt);
        check_val("illegal write count", eIw, illegalWriteCnt);
        check_val("illegal function count", eIf, illegalFuncCnt);
        check_val("illegal register count", eIr, illegalRegCnt);
    endtask
    // Checksum appended low byte first
    function automatic bytes_t with_crc(input bytes_t b);
        logic [15:0] c;
        c = modbus_wr_pkg::CRC_INIT;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ modbus_wr_pkg::CRC_POLY) : (c >> 1);
            end
        end
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        return b;
    endfunction
    // Base register addresses go on the wire; six-digit references are a master-side view only
    function automatic bytes_t sgl(input logic [15:0] a, input logic [15:0] d);
        return '{STN, 8'h06, a[15:8], a[7:0], d[15:8], d[7:0]};
    endfunction
    function automatic bytes_t mbody(input logic [15:0] st, input logic [15:0] cnt, input int n, input logic [15:0] v);
        bytes_t b;
        logic [15:0] w;
        b = '{STN, 8'h10, st[15:8], st[7:0], cnt[15:8], cnt[7:0], n[7:0]};
        for (int i = 0; i < n; i++) begin
            w = v + 16'(i / 2);
            b.push_back((i % 2 == 1) ? w[7:0] : w[15:8]);
        end
        return b;
    endfunction
    // Send one frame, wait for the reply under a bound, compare byte by byte
    task automatic transact(input bytes_t fr, input bytes_t expRep);
        int w;
        u_master.clear();
        u_master.send(fr);
        w = 0;
        while (u_master.done !== 1'b1 && w < 600) begin
            @(negedge mclk);
            w++;
        end
        check_val("reply length", expRep.size(), u_master.reply.size());
        foreach (expRep[i]) check_val("reply byte", expRep[i], u_master.reply[i]);
        if (expRep.size() > 0) check_val("last marker position", expRep.size(), u_master.lastPos);
        repeat (3) @(negedge mclk);
    endtask
    task automatic exc(input bytes_t body, input logic [7:0] code);
        bytes_t e;
        e = '{STN, body[1] | 8'h80, code};
        transact(with_crc(body), with_crc(e));
    endtask
    // ==========================================
    // Scenarios
    task automatic t_single_ok();
        logic [15:0] tbl[10];
        bytes_t fr;
        tbl = '{16'h0100, 16'h1234, 16'h0107, 16'hABCD, 16'h0180, 16'h00FF, 16'h0200, 16'h0001, 16'h0205, 16'h0059};
        u_master.stall = 1'b1; // Sink stalls to prove each reply byte after the first is held
        for (int i = 0; i < 10; i += 2) begin
            wrQ.delete();
            fr = with_crc(sgl(tbl[i], tbl[i+1]));
            transact(fr, fr);
            check_val("single write", {tbl[i], tbl[i+1]}, (wrQ.size() == 1) ? wrQ[0] : 32'h0000_0000);
        end
        u_master.stall = 1'b0;
        check_counts();
    endtask
    task automatic t_single_err();
        wrQ.delete();
        exc(sgl(16'h0108, 16'h0001), 8'h02);
        eIa++;
        eIw++;
        check_counts();
        exc(sgl(16'h0180, 16'h0100), 8'h03);
        eIw++;
        check_counts();
        exc('{STN, 8'h06, 8'h01, 8'h00, 8'h00}, 8'h03);
        eBp++;
        check_counts();
        check_val("writes on refusal", 0, wrQ.size());
    endtask
    task automatic t_loop();
        bytes_t fr;
        wrQ.delete();
        fr = with_crc('{STN, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h5A});
        transact(fr, fr);
        exc('{STN, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34}, 8'h03);
        eIf++;
        check_counts();
        exc('{STN, 8'h08, 8'h00, 8'h00, 8'h12}, 8'h03);
        eBp++;
        exc('{STN, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 8'h01);
        eIf++;
        check_counts();
        check_val("loopback writes", 0, wrQ.size());
    endtask
    task automatic t_multi();
        bytes_t b;
        wrQ.delete();
        b = mbody(16'h0104, 16'h0004, 8, 16'h2000);
        transact(with_crc(b), with_crc(b[0:5]));
        check_val("multi write count", 4, wrQ.size());
        foreach (wrQ[i]) check_val("multi write", {16'h0104 + 16'(i), 16'h2000 + 16'(i)}, wrQ[i]);
        wrQ.delete();
        exc(mbody(16'h0100, 16'h0000, 0, 16'h0000), 8'h03);
        exc(mbody(16'h0100, 16'h0065, 202, 16'h0000), 8'h03);
        eIr += 2;
        eIw += 2;
        check_counts();
        exc(mbody(16'h0100, 16'h0064, 200, 16'h0000), 8'h02);
        exc(mbody(16'h0106, 16'h0003, 6, 16'h0001), 8'h02);
        eIa += 2;
        eIw += 2;
        check_counts();
        exc('{STN, 8'h10, 8'h01, 8'h00, 8'h00, 8'h01}, 8'h03);
        eBp++;
        exc(mbody(16'h0100, 16'h0002, 3, 16'h0000), 8'h03);
        eBp++;
        eIw++;
        check_counts();
        exc(mbody(16'h0180, 16'h0001, 2, 16'h0100), 8'h03);
        eIw++;
        check_counts();
        check_val("multi writes on refusal", 0, wrQ.size());
    endtask
    task automatic t_drop();
        bytes_t fr;
        wrQ.delete();
        fr = with_crc(sgl(16'h0100, 16'h0005));
        fr[7] = fr[7] ^ 8'h01;
        transact(fr, none);
        fr = sgl(16'h0100, 16'h0005);
        fr[0] = 8'h12;
        transact(with_crc(fr), none);
        transact(with_crc(mbody(16'h0100, 16'h0001, 251, 16'h0000)), none);
        check_counts();
        check_val("dropped frame writes", 0, wrQ.size());
    endtask
    // ==========================================
    // Verdict, watchdog and main sequence
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Run needs about 13 us; the limit leaves ample slack
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end
    initial begin
        arst_n = 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        arst_n = 1'b1;
        check_counts();
        t_single_ok();
        t_single_err();
        t_loop();
        t_multi();
        t_drop();
        complete_run();
    end
endmodule
